/* File: hdl/isq_pkg.sv */
// ****************************************
// Sequencer constants
// ****************************************
package isq_pkg;

   localparam int PC_W = 11;
   localparam int INST_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_IRQ = 10;
   localparam int IRQ_ID_W = 4;
   localparam logic [10:0] RESET_VEC = 11'h000;
   localparam logic [10:0] VEC_BASE = 11'h004;
   localparam int VEC_SHIFT = 2;
   localparam logic [10:0] PC_MAX = 11'h7ff;
   localparam logic [10:0] PC_STEP = 11'h001;
   localparam int STACK_DEPTH = 8;
   localparam int STACK_AW = 3;
   localparam logic [3:0] STACK_LEVEL_FULL = 4'h8;
   localparam logic [3:0] STACK_LEVEL_EMPTY = 4'h0;
   localparam int OP_MSB = 15;
   localparam int OP_LSB = 11;
   localparam int DEST_BIT = 8;
   localparam int EMI_BIT = 0;
   localparam int ST_C = 0;
   localparam int ST_AC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [15:0] INST_RST = 16'h0000;
   localparam logic [7:0] DAA_LOW = 8'h06;
   localparam logic [7:0] DAA_HIGH = 8'h60;
   localparam logic [3:0] BCD_MAX = 4'h9;

   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} isq_phase_e;

   typedef enum logic [4:0] {
      OP_NOP, OP_MOVI, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR, OP_XOR,
      OP_CPL, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_INC, OP_DEC, OP_UNCONDITIONAL_JUMP,
      OP_CALL, OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN, OP_SZ, OP_SNZ,
      OP_WRITE_PC_LOW, OP_READ_PC_LOW, OP_EMI
   } isq_op_e;

endpackage : isq_pkg

/* File: hdl/isq_sequencer.sv */
// Summary of operation
// - System clock is split into four phases; four phases make one instruction cycle.
// - Phase one advances the program counter and starts the next fetch.
// - Phases two to four decode and execute, overlapped with the next fetch.
// - Non-sequential counter changes cost one extra cycle; the prefetch is flushed.
// - Branches take two cycles: obtain target, then perform the branch.
// - Sequential execution adds exactly one to the counter per instruction.
// - Counter is 11 bits; only the low byte is software accessible.
// - Writing the low byte jumps within the current 256-word page.
// - Writing the low byte inserts one dummy cycle for the prefetch.
// - A taken skip discards the fetched instruction and runs a dummy cycle.
// - Jump, call, interrupt and reset load the target into the counter.
// - Stack holds only counter values and is invisible to software.
// - Call and interrupt push the fetch address (prog_addr); returns load it into the counter.
// - After reset the stack pointer shows the empty top position.
// - Full stack holds an interrupt pending until a return frees a level.
// - Call on a full stack still runs, losing the oldest entry.
// - ALU is 8 bits wide and updates the status flags.
// - ALU offers add, subtract, adjust, logic, rotates, increment, decrement.
// - Program memory holds 16-bit words up to address 7FF.
// - After reset execution starts at address 000.
// - Interrupt vectors are four words apart from 004 to 028.
module isq_sequencer
(
   input wire logic core_clk,
   input wire logic nrst,
   output logic [10:0] prog_addr,
   input wire logic [15:0] prog_data,
   input wire logic [9:0] irq_req,
   input wire logic [9:0] irq_enable,
   output logic phase_one,
   output logic phase_two,
   output logic phase_three,
   output logic phase_four,
   output logic [7:0] accumulator,
   output logic [3:0] status,
   output logic [7:0] pc_low_byte,
   output logic global_int_en,
   output logic int_ack,
   output logic [3:0] int_id,
   output logic mem_wr_en,
   output logic [7:0] mem_wr_data
);

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [10:0] vector_of(input logic [3:0] id);
      vector_of = isq_pkg::VEC_BASE + {5'h00, id, 2'b00};
   endfunction : vector_of

   function automatic logic [3:0] first_pending(input logic [9:0] p);
      first_pending = 4'h0;
      for (int i = isq_pkg::NUM_IRQ - 1; i >= 0; i--)
      begin
         if (p[i])
         begin
            first_pending = 4'(i);
         end
      end
   endfunction : first_pending

   // ****************************************
   // Phase generator
   // ****************************************
   isq_pkg::isq_phase_e phase;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase <= isq_pkg::PH_ONE;
      end
      else
      begin
         case (phase)
            isq_pkg::PH_ONE: phase <= isq_pkg::PH_TWO;
            isq_pkg::PH_TWO: phase <= isq_pkg::PH_THREE;
            isq_pkg::PH_THREE: phase <= isq_pkg::PH_FOUR;
            isq_pkg::PH_FOUR: phase <= isq_pkg::PH_ONE;
            default: phase <= isq_pkg::PH_ONE;
         endcase
      end
   end

   assign phase_one = (phase == isq_pkg::PH_ONE);
   assign phase_two = (phase == isq_pkg::PH_TWO);
   assign phase_three = (phase == isq_pkg::PH_THREE);
   assign phase_four = (phase == isq_pkg::PH_FOUR);

   // ****************************************
   // Decode
   // ****************************************
   logic [10:0] pc;
   logic [15:0] fetch_word;
   logic fetch_valid;
   logic [15:0] ir;
   logic exec_valid;
   logic [9:0] pending;
   logic stack_full;
   logic stack_empty;
   logic [10:0] stack_top;
   isq_pkg::isq_op_e op;
   logic exec;
   logic is_jump;
   logic is_call;
   logic is_return;
   logic is_interrupt_return;
   logic is_pcl_wr;
   logic skip_taken;
   logic instr_redirect;
   logic int_take;
   logic redirect;
   logic [3:0] next_int_id;
   logic [10:0] next_pc;

   assign op = isq_pkg::isq_op_e'(ir[isq_pkg::OP_MSB:isq_pkg::OP_LSB]);
   assign exec = exec_valid && phase_four;
   assign is_jump = exec && (op == isq_pkg::OP_UNCONDITIONAL_JUMP);
   assign is_call = exec && (op == isq_pkg::OP_CALL);
   assign is_interrupt_return = exec && (op == isq_pkg::OP_INTERRUPT_RETURN);
   assign is_return = exec && ((op == isq_pkg::OP_SUBROUTINE_RETURN) || is_interrupt_return);
   assign is_pcl_wr = exec && (op == isq_pkg::OP_WRITE_PC_LOW);
   assign skip_taken = exec && (((op == isq_pkg::OP_SZ) && (accumulator == 8'h00)) ||
                                ((op == isq_pkg::OP_SNZ) && (accumulator != 8'h00)));
   assign instr_redirect = is_jump || is_call || is_return || is_pcl_wr || skip_taken;
   // Interrupt waits while stack is full or an instruction already redirects
   assign int_take = phase_four && global_int_en && (|pending) && !stack_full
                     && !instr_redirect;
   assign redirect = instr_redirect || int_take;
   assign next_int_id = first_pending(pending);

   always_comb
   begin
      next_pc = pc;
      if (int_take)
      begin
         next_pc = vector_of(next_int_id);
      end
      else if (is_jump || is_call)
      begin
         next_pc = ir[10:0];
      end
      else if (is_return)
      begin
         next_pc = stack_top;
      end
      else if (is_pcl_wr)
      begin
         next_pc = {pc[10:8], accumulator};
      end
   end

   // ****************************************
   // Program counter and fetch
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pc <= isq_pkg::RESET_VEC;
         prog_addr <= isq_pkg::RESET_VEC;
      end
      else if (phase_one)
      begin
         prog_addr <= pc;
         pc <= pc + isq_pkg::PC_STEP;
      end
      else if (redirect)
      begin
         pc <= next_pc;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fetch_word <= isq_pkg::INST_RST;
         fetch_valid <= 1'b0;
         ir <= isq_pkg::INST_RST;
         exec_valid <= 1'b0;
      end
      else if (phase_four)
      begin
         fetch_word <= prog_data;
         fetch_valid <= !redirect;
      end
      else if (phase_one)
      begin
         ir <= fetch_word;
         exec_valid <= fetch_valid;
      end
   end

   // ****************************************
   // Return stack
   // ****************************************
   // Pushes the address of the flushed prefetch
   isq_stack u_stack
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .push(is_call || int_take),
      .pop(is_return),
      .push_data(prog_addr),
      .top(stack_top),
      .full(stack_full),
      .empty(stack_empty)
   );

   // ****************************************
   // Interrupts
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pending <= '0;
         global_int_en <= 1'b0;
         int_ack <= 1'b0;
         int_id <= 4'h0;
      end
      else
      begin
         int_ack <= int_take;
         if (int_take)
         begin
            int_id <= next_int_id;
            global_int_en <= 1'b0;
         end
         else if (is_interrupt_return)
         begin
            global_int_en <= 1'b1;
         end
         else if (exec && (op == isq_pkg::OP_EMI))
         begin
            global_int_en <= ir[isq_pkg::EMI_BIT];
         end
         // New request wins over the acknowledge clear
         for (int i = 0; i < isq_pkg::NUM_IRQ; i++)
         begin
            if (irq_req[i] && irq_enable[i])
            begin
               pending[i] <= 1'b1;
            end
            else if (int_take && (next_int_id == 4'(i)))
            begin
               pending[i] <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // ALU
   // ****************************************
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] next_result;
   logic [3:0] next_status;
   logic alu_op;
   logic write_acc;
   logic [7:0] add_b;
   logic add_cin;

   assign opnd = ir[7:0];

   always_comb
   begin
      sum = 9'h000;
      nib = 5'h00;
      next_result = accumulator;
      next_status = status;
      alu_op = 1'b1;
      add_b = opnd;
      add_cin = 1'b0;
      case (op)
         isq_pkg::OP_ADD, isq_pkg::OP_ADC, isq_pkg::OP_SUB, isq_pkg::OP_SBC:
         begin
            add_b = ((op == isq_pkg::OP_SUB) || (op == isq_pkg::OP_SBC)) ? ~opnd : opnd;
            add_cin = (op == isq_pkg::OP_ADD) ? 1'b0 :
                      (op == isq_pkg::OP_SUB) ? 1'b1 : status[isq_pkg::ST_C];
            sum = {1'b0, accumulator} + {1'b0, add_b} + {8'h00, add_cin};
            nib = {1'b0, accumulator[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
            next_result = sum[7:0];
            next_status[isq_pkg::ST_C] = sum[8];
            next_status[isq_pkg::ST_AC] = nib[4];
            next_status[isq_pkg::ST_OV] = (accumulator[7] == add_b[7]) && (sum[7] != add_b[7]);
         end
         isq_pkg::OP_DAA:
         begin
            sum = {1'b0, accumulator};
            if ((accumulator[3:0] > isq_pkg::BCD_MAX) || status[isq_pkg::ST_AC])
            begin
               sum = sum + {1'b0, isq_pkg::DAA_LOW};
            end
            if ((sum[7:4] > isq_pkg::BCD_MAX) || status[isq_pkg::ST_C] || sum[8])
            begin
               sum = sum + {1'b0, isq_pkg::DAA_HIGH};
            end
            next_result = sum[7:0];
            next_status[isq_pkg::ST_C] = sum[8] || status[isq_pkg::ST_C];
         end
         isq_pkg::OP_AND: next_result = accumulator & opnd;
         isq_pkg::OP_OR: next_result = accumulator | opnd;
         isq_pkg::OP_XOR: next_result = accumulator ^ opnd;
         isq_pkg::OP_CPL: next_result = ~accumulator;
         isq_pkg::OP_RR: next_result = {accumulator[0], accumulator[7:1]};
         isq_pkg::OP_RL: next_result = {accumulator[6:0], accumulator[7]};
         isq_pkg::OP_RRC:
         begin
            next_result = {status[isq_pkg::ST_C], accumulator[7:1]};
            next_status[isq_pkg::ST_C] = accumulator[0];
         end
         isq_pkg::OP_RLC:
         begin
            next_result = {accumulator[6:0], status[isq_pkg::ST_C]};
            next_status[isq_pkg::ST_C] = accumulator[7];
         end
         isq_pkg::OP_INC: next_result = accumulator + 8'h01;
         isq_pkg::OP_DEC: next_result = accumulator - 8'h01;
         isq_pkg::OP_MOVI: next_result = opnd;
         isq_pkg::OP_READ_PC_LOW: next_result = pc_low_byte;
         default: alu_op = 1'b0;
      endcase
      if (alu_op && (op != isq_pkg::OP_RR) && (op != isq_pkg::OP_RL)
          && (op != isq_pkg::OP_RRC) && (op != isq_pkg::OP_RLC))
      begin
         next_status[isq_pkg::ST_Z] = (next_result == 8'h00);
      end
   end

   assign write_acc = exec && alu_op && !ir[isq_pkg::DEST_BIT];
   // Low byte as seen by software: address of the executing instruction plus one
   assign pc_low_byte = prog_addr[7:0];

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         accumulator <= isq_pkg::ACC_RST;
         status <= isq_pkg::STATUS_RST;
         mem_wr_en <= 1'b0;
         mem_wr_data <= isq_pkg::ACC_RST;
      end
      else
      begin
         mem_wr_en <= exec && alu_op && ir[isq_pkg::DEST_BIT];
         if (exec && alu_op)
         begin
            status <= next_status;
            mem_wr_data <= next_result;
         end
         if (write_acc)
         begin
            accumulator <= next_result;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_phase_onehot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
      else $error("phases not one-hot");
   a_phase_ring: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four
      ##1 phase_one) else $error("phase order broken");
   a_fetch_step: assert property (phase_one && !redirect |=> pc == $past(pc) + 11'h001
      && prog_addr == $past(pc)) else $error("fetch did not step");
   a_flush_dummy: assert property (redirect |-> ##2 !exec_valid)
      else $error("prefetch not flushed");
   a_page_jump: assert property (is_pcl_wr |=> pc == {$past(pc[10:8]), $past(accumulator)})
      else $error("low byte jump left page");
   a_call_target: assert property (is_call |=> pc == $past(ir[10:0]) ##3 prog_addr == $past(
      ir[10:0], 4)) else $error("call target not fetched");
   a_return_pc: assert property (is_return |=> pc == $past(stack_top))
      else $error("return address wrong");
   a_int_inhibit: assert property (stack_full && phase_four && (|pending) |=> !int_ack
      && (|pending)) else $error("interrupt taken on full stack");
   a_int_vector: assert property (int_take |=> int_ack && pc == vector_of(int_id))
      else $error("vector address wrong");
   a_zero_flag: assert property (write_acc && op == isq_pkg::OP_INC |=>
      status[isq_pkg::ST_Z] == (accumulator == 8'h00)) else $error("zero flag wrong");

   c_call: cover property (is_call ##[4:8] exec_valid);
   c_skip: cover property (skip_taken);
   c_int_ack: cover property (int_ack);
   c_int_held: cover property (stack_full && (|pending) && global_int_en ##[1:40] int_ack);

endmodule : isq_sequencer

/* File: hdl/isq_stack.sv */
// ****************************************
// Return address stack
// ****************************************
module isq_stack
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic push,
   input wire logic pop,
   input wire logic [10:0] push_data,
   output logic [10:0] top,
   output logic full,
   output logic empty
);

   logic [10:0] mem [isq_pkg::STACK_DEPTH];
   logic [isq_pkg::STACK_AW-1:0] wr_idx;
   logic [isq_pkg::STACK_AW:0] level;

   assign full = (level == isq_pkg::STACK_LEVEL_FULL);
   assign empty = (level == isq_pkg::STACK_LEVEL_EMPTY);

   // Oldest entry is overwritten on overflow
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_idx] <= push_data;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_idx <= '0;
         level <= isq_pkg::STACK_LEVEL_EMPTY;
         top <= isq_pkg::RESET_VEC;
      end
      else if (push)
      begin
         wr_idx <= wr_idx + 1'b1;
         level <= full ? level : level + 1'b1;
         top <= push_data;
      end
      else if (pop && !empty)
      begin
         wr_idx <= wr_idx - 1'b1;
         level <= level - 1'b1;
         top <= mem[wr_idx - 2'd2];
      end
   end

endmodule : isq_stack

/* File: test/isq_prog_mem.sv */
// ****************************************
// Program memory model
// ****************************************
module isq_prog_mem
(
   input wire logic core_clk,
   input wire logic slow,
   input wire logic [10:0] prog_addr,
   output logic [15:0] prog_data
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] words [0:2047];
   logic [10:0] last_addr;
   logic settled;

   always_ff @(posedge core_clk)
   begin
      last_addr <= prog_addr;
      settled <= (last_addr == prog_addr);
   end

   // Slow reply shows the inverse word until the address stood two edges
   assign prog_data = (!slow || (settled && last_addr == prog_addr)) ?
      words[prog_addr] : ~words[prog_addr];

endmodule : isq_prog_mem

/* File: test/isq_sequencer_bench.sv */
// ****************************************
// Sequencer bench
// ****************************************
module isq_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic slow = 1'b0;
   logic [9:0] irq_req = 10'h000;
   logic [9:0] irq_enable = 10'h000;
   logic [10:0] prog_addr;
   logic [15:0] prog_data;
   logic phase_one, phase_two, phase_three, phase_four;
   logic [7:0] accumulator;
   logic [3:0] status;
   logic [7:0] pc_low_byte;
   logic global_int_en, int_ack, mem_wr_en;
   logic [3:0] int_id;
   logic [7:0] mem_wr_data;
   int error_cnt = 0;
   int check_count = 0;

   always #25 core_clk = ~core_clk;

   isq_sequencer isq_sequencer_i
   (
      .core_clk(core_clk), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
      .irq_req(irq_req), .irq_enable(irq_enable), .phase_one(phase_one),
      .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four),
      .accumulator(accumulator), .status(status), .pc_low_byte(pc_low_byte),
      .global_int_en(global_int_en), .int_ack(int_ack), .int_id(int_id),
      .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data)
   );

   isq_prog_mem isq_prog_mem_i
   (
      .core_clk(core_clk), .slow(slow), .prog_addr(prog_addr), .prog_data(prog_data)
   );

   // ****************************************
   // Helpers
   // ****************************************
   task automatic final_report();
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask : check

   task automatic hold_reset(input logic slow_reply);
      @(posedge core_clk);
      nrst <= 1'b0;
      irq_req <= 10'h000;
      slow <= slow_reply;
      for (int a = 0; a < 2048; a++)
         isq_prog_mem_i.words[a] = 16'h0000;
   endtask : hold_reset

   task automatic load(input logic [10:0] a, input isq_pkg::isq_op_e op,
                       input logic [10:0] arg);
      isq_prog_mem_i.words[a] = {op, arg};
   endtask : load

   task automatic release_reset();
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      @(negedge core_clk);
   endtask : release_reset

   // Called at a falling edge; checks the address fetched next against exp
   task automatic expect_fetch(input logic [10:0] exp);
      int n;
      n = 0;
      while (phase_one !== 1'b1 && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      check("prog_addr", 16'(exp), 16'(prog_addr));
   endtask : expect_fetch

   task automatic wait_ack();
      int n;
      n = 0;
      do
      begin
         @(negedge core_clk);
         n++;
      end
      while (int_ack !== 1'b1 && n < 60);
      check("int_ack", 16'h0001, 16'(int_ack));
   endtask : wait_ack

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_phases_seq();
      hold_reset(1'b1);
      load(11'h000, isq_pkg::OP_MOVI, 11'h03c);
      load(11'h001, isq_pkg::OP_ADD, 11'h0d0);
      load(11'h002, isq_pkg::OP_XOR, 11'h0ff);
      release_reset();
      for (int i = 0; i < 8; i++)
      begin
         check("phases", 16'(4'b1000 >> (i % 4)),
               16'({phase_one, phase_two, phase_three, phase_four}));
         @(negedge core_clk);
      end
      expect_fetch(11'h002);
      expect_fetch(11'h003);
      check("accumulator", 16'h000c, 16'(accumulator));
      check("carry", 16'h0001, 16'(status[isq_pkg::ST_C]));
      expect_fetch(11'h004);
      check("accumulator", 16'h00f3, 16'(accumulator));
   endtask : test_phases_seq

   task automatic test_jump();
      hold_reset(1'b0);
      load(11'h000, isq_pkg::OP_UNCONDITIONAL_JUMP, 11'h123);
      load(11'h001, isq_pkg::OP_MOVI, 11'h055);
      load(11'h123, isq_pkg::OP_MOVI, 11'h077);
      release_reset();
      expect_fetch(11'h000);
      expect_fetch(11'h001);
      expect_fetch(11'h123);
      expect_fetch(11'h124);
      check("accumulator", 16'h0000, 16'(accumulator));
      expect_fetch(11'h125);
      check("accumulator", 16'h0077, 16'(accumulator));
   endtask : test_jump

   task automatic test_call();
      hold_reset(1'b0);
      load(11'h000, isq_pkg::OP_CALL, 11'h200);
      load(11'h001, isq_pkg::OP_MOVI, 11'h011);
      load(11'h200, isq_pkg::OP_MOVI, 11'h022);
      load(11'h201, isq_pkg::OP_SUBROUTINE_RETURN, 11'h000);
      release_reset();
      expect_fetch(11'h000);
      expect_fetch(11'h001);
      expect_fetch(11'h200);
      expect_fetch(11'h201);
      expect_fetch(11'h202);
      check("accumulator", 16'h0022, 16'(accumulator));
      expect_fetch(11'h001);
      expect_fetch(11'h002);
      expect_fetch(11'h003);
      check("accumulator", 16'h0011, 16'(accumulator));
   endtask : test_call

   task automatic test_page();
      hold_reset(1'b1);
      load(11'h000, isq_pkg::OP_UNCONDITIONAL_JUMP, 11'h305);
      load(11'h305, isq_pkg::OP_MOVI, 11'h040);
      load(11'h306, isq_pkg::OP_WRITE_PC_LOW, 11'h000);
      release_reset();
      expect_fetch(11'h000);
      expect_fetch(11'h001);
      expect_fetch(11'h305);
      expect_fetch(11'h306);
      expect_fetch(11'h307);
      expect_fetch(11'h340);
      check("pc_low_byte", 16'h0040, 16'(pc_low_byte));
   endtask : test_page

   task automatic test_alu_skip();
      hold_reset(1'b0);
      load(11'h000, isq_pkg::OP_MOVI, 11'h009);
      load(11'h001, isq_pkg::OP_ADD, 11'h001);
      load(11'h002, isq_pkg::OP_DAA, 11'h000);
      load(11'h003, isq_pkg::OP_SUB, 11'h010);
      load(11'h004, isq_pkg::OP_SZ, 11'h000);
      load(11'h005, isq_pkg::OP_MOVI, 11'h0ee);
      load(11'h006, isq_pkg::OP_SNZ, 11'h000);
      load(11'h007, isq_pkg::OP_DEC, 11'h100);
      load(11'h008, isq_pkg::OP_READ_PC_LOW, 11'h000);
      release_reset();
      expect_fetch(11'h000);
      expect_fetch(11'h001);
      expect_fetch(11'h002);
      expect_fetch(11'h003);
      expect_fetch(11'h004);
      check("accumulator", 16'h0010, 16'(accumulator));
      expect_fetch(11'h005);
      check("accumulator", 16'h0000, 16'(accumulator));
      check("status", 16'h0007, 16'(status));
      expect_fetch(11'h006);
      expect_fetch(11'h007);
      check("accumulator", 16'h0000, 16'(accumulator));
      expect_fetch(11'h008);
      repeat (3) @(negedge core_clk);
      check("mem_wr_en", 16'h0001, 16'(mem_wr_en));
      check("mem_wr_data", 16'h00ff, 16'(mem_wr_data));
      check("accumulator", 16'h0000, 16'(accumulator));
      expect_fetch(11'h009);
      check("mem_wr_en", 16'h0000, 16'(mem_wr_en));
      check("status", 16'h0003, 16'(status));
      expect_fetch(11'h00a);
      check("accumulator", 16'h0009, 16'(accumulator));
   endtask : test_alu_skip

   task automatic test_stack_full();
      int n;
      hold_reset(1'b0);
      irq_enable <= 10'h3ff;
      load(11'h000, isq_pkg::OP_CALL, 11'h100);
      for (int k = 0; k < 7; k++)
         load(11'h100 + 11'(k), isq_pkg::OP_CALL, 11'h101 + 11'(k));
      load(11'h107, isq_pkg::OP_EMI, 11'h001);
      load(11'h108, isq_pkg::OP_SUBROUTINE_RETURN, 11'h000);
      release_reset();
      @(posedge core_clk);
      irq_req <= 10'h004;
      @(posedge core_clk);
      irq_req <= 10'h000;
      n = 1;
      while (int_ack !== 1'b1 && n < 120)
      begin
         @(negedge core_clk);
         n++;
      end
      check("ack_edge", 16'h0050, 16'(n));
      check("int_id", 16'h0002, 16'(int_id));
      expect_fetch(11'h00c);
   endtask : test_stack_full

   task automatic test_irq(input logic [3:0] id);
      logic [10:0] vec;
      vec = isq_pkg::VEC_BASE + (11'(id) << isq_pkg::VEC_SHIFT);
      hold_reset(1'b0);
      irq_enable <= 10'h3ff;
      load(11'h000, isq_pkg::OP_EMI, 11'h001);
      load(vec, isq_pkg::OP_INTERRUPT_RETURN, 11'h000);
      release_reset();
      expect_fetch(11'h000);
      expect_fetch(11'h001);
      expect_fetch(11'h002);
      check("global_int_en", 16'h0001, 16'(global_int_en));
      @(posedge core_clk);
      irq_req <= (10'h001 << id) | 10'h200;
      @(posedge core_clk);
      irq_req <= 10'h000;
      wait_ack();
      check("int_id", 16'(id), 16'(int_id));
      check("global_int_en", 16'h0000, 16'(global_int_en));
      expect_fetch(vec);
      if (id != 4'h9)
      begin
         wait_ack();
         check("int_id", 16'h0009, 16'(int_id));
         expect_fetch(11'h028);
      end
   endtask : test_irq

   initial
   begin
      test_phases_seq();
      test_jump();
      test_call();
      test_page();
      test_alu_skip();
      test_stack_full();
      for (int id = 0; id < 10; id++)
         test_irq(4'(id));
      final_report();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      final_report();
   end

endmodule : isq_sequencer_bench
